// *** rtl/flash_ctrl_pkg.sv ***
package flash_ctrl_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_SETUP = 8'h00;
   localparam logic [7:0] OFF_FAULT_SETUP = 8'h04;
   localparam logic [7:0] OFF_STATE = 8'h08;
   localparam logic [7:0] OFF_FAULT_STATE = 8'h0c;
   localparam logic [7:0] OFF_SECURITY = 8'h10;
   localparam logic [7:0] OFF_PROTECT = 8'h14;
   localparam logic [7:0] OFF_OPTION = 8'h18;
   localparam logic [7:0] OFF_COMMAND = 8'h1c;
   localparam logic [7:0] OFF_KEY0 = 8'h20;
   localparam logic [7:0] OFF_SEC_INFO = 8'h30;
   // Field positions
   localparam int BIT_IRQ_EN = 0;
   localparam int BIT_DONE = 7;
   localparam int BIT_ACCERR = 4;
   localparam int BIT_SINGLE = 0;
   // Command codes
   localparam logic [2:0] CMD_VERIFY_KEY = 3'h1;
   localparam logic [2:0] CMD_ERASE_VERIFY = 3'h2;
   localparam logic [2:0] CMD_ERASE_ALL = 3'h3;
   localparam logic [2:0] CMD_UNSECURE = 3'h4;
   // Configuration field
   localparam logic [23:0] CFG_BASE = 24'hff_fe00;
   localparam logic [2:0] CFG_LAST = 3'h7;
   localparam logic [2:0] CFG_PROT_IDX = 3'h6;
   localparam logic [2:0] CFG_SEC_IDX = 3'h7;
   localparam int NUM_KEYS = 4;
   localparam logic [15:0] KEY_ZERO = 16'h0000;
   localparam logic [15:0] KEY_ONES = 16'hffff;
   // Security encodings
   localparam logic [1:0] SEC_UNSEC = 2'h2;
   localparam logic [1:0] BACKDOOR_ON = 2'h2;
   // Fallback values: fully protected, secured, backdoor off
   localparam logic [7:0] PROT_FULL = 8'h00;
   localparam logic [7:0] OPT_DEFAULT = 8'hff;
   localparam logic [7:0] SEC_DEFAULT = 8'h00;
   typedef struct packed {
      logic [1:0] backdoor_enable_field;
      logic [3:0] spare;
      logic [1:0] security_state_field;
   } security_t;
   typedef enum logic [5:0] {
      ST_RD_REQ = 6'h01,
      ST_RD_WAIT = 6'h02,
      ST_FIN = 6'h04,
      ST_IDLE = 6'h08,
      ST_KEY = 6'h10,
      ST_ENG = 6'h20
   } ctrl_state_t;
endpackage

// *** rtl/flash_security_irq_init_ctrl.sv ***
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ns
// Behaviour
// - Command interrupt asserted while done flag and its enable are set.
// - Error interrupt asserted while single-fault flag and its enable are set.
// - Wait mode changes nothing; command interrupt can wake the processor.
// - Stop request is acknowledged only after a running command finishes.
// - Reset loads security register from the security byte in configuration field.
// - Security register is loaded only at reset, not on reprogramming.
// - With backdoor enabled, verify-key compares four 16-bit keys with stored keys.
// - All keys matching forces security state field to unsecure encoding.
// - All-zero and all-ones keys never count as valid.
// - Program and EEPROM reads refused while verify-key runs.
// - A wrong key blocks further verify-key commands until reset.
// - Verify-key leaves stored byte, stored keys and protection unchanged.
// - Erase-verify in special mode finding all erased unsecures and enables debug.
// - Each reset loads configuration, both protections, option and security.
// - Errors during reset load fall back to fully protected, secured defaults.
// - Double-bit fault during reset load sets both verify fault bits.
// - Done flag low through initialization, set when it completes.
// - Processor accesses stalled during part of init, reads allowed afterwards.
// - Reset aborts a running command immediately.
module flash_security_irq_init_ctrl
   import flash_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Configuration field read port
   output logic nvm_rd,
   output logic [23:0] nvm_addr,
   input wire logic [15:0] nvm_rdata,
   input wire logic nvm_valid,
   input wire logic nvm_err,
   input wire logic nvm_dbl_fault,
   // Array engine for erase and verify commands
   output logic eng_start,
   output logic [2:0] eng_cmd,
   input wire logic eng_done,
   input wire logic eng_erased,
   // System side
   input wire logic rd_single_fault,
   input wire logic special_mode,
   input wire logic stop_req,
   output logic stop_ack,
   output logic cpu_hold,
   output logic read_block,
   output logic cmd_irq,
   output logic fault_irq,
   output logic secured,
   output logic debug_full_en,
   output flash_ctrl_pkg::security_t security_out
);
   import flash_ctrl_pkg::*;

   ctrl_state_t state_q;
   logic [2:0] idx_q;
   logic err_seen_q;
   logic cmd_done_flag_q;
   logic cmd_done_irq_en_q;
   logic single_fault_irq_en_q;
   logic single_fault_flag_q;
   logic accerr_q;
   logic [1:0] verify_fault_bits_q;
   security_t security_reg_q;
   logic [7:0] pflash_protect_reg_q;
   logic [7:0] eeprom_protect_reg_q;
   logic [7:0] option_reg_q;
   logic [15:0] key_stored_q [NUM_KEYS];
   logic [15:0] key_in_q [NUM_KEYS];
   logic key_lock_q;
   logic debug_unsec_q;
   logic [2:0] cmd_q;
   logic [31:0] rd_mux;
   logic setup_ph;
   logic acc_wr;
   logic launch;
   logic cmd_ok;
   logic keys_match;
   logic key_phase;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   // Key is valid only if it matches and is not a blank pattern
   function automatic logic key_good(input logic [15:0] p, input logic [15:0] s);
      return (p == s) && (p != KEY_ZERO) && (p != KEY_ONES);
   endfunction

   // Bus: no wait states; read data leaves a flip-flop loaded in the setup phase
   assign setup_ph = psel & ~penable;
   assign acc_wr = psel & penable & pready & pwrite;
   assign launch = acc_wr & hit(paddr, OFF_COMMAND) & (state_q == ST_IDLE) & cmd_done_flag_q;
   assign cmd_ok = (pwdata[2:0] == CMD_ERASE_VERIFY) | (pwdata[2:0] == CMD_ERASE_ALL)
                 | (pwdata[2:0] == CMD_UNSECURE)
                 | ((pwdata[2:0] == CMD_VERIFY_KEY) & ~key_lock_q
                    & (security_reg_q.backdoor_enable_field == BACKDOOR_ON));
   assign key_phase = (state_q == ST_KEY);

   always_comb begin
      keys_match = 1'b1;
      for (int i = 0; i < NUM_KEYS; i++) begin
         keys_match = keys_match & key_good(key_in_q[i], key_stored_q[i]);
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit(paddr, OFF_SETUP)) begin
         rd_mux[BIT_IRQ_EN] = cmd_done_irq_en_q;
      end else if (hit(paddr, OFF_FAULT_SETUP)) begin
         rd_mux[BIT_IRQ_EN] = single_fault_irq_en_q;
      end else if (hit(paddr, OFF_STATE)) begin
         rd_mux[BIT_DONE] = cmd_done_flag_q;
         rd_mux[BIT_ACCERR] = accerr_q;
         rd_mux[1:0] = verify_fault_bits_q;
      end else if (hit(paddr, OFF_FAULT_STATE)) begin
         rd_mux[BIT_SINGLE] = single_fault_flag_q;
      end else if (hit(paddr, OFF_SECURITY)) begin
         rd_mux[7:0] = security_reg_q;
      end else if (hit(paddr, OFF_PROTECT)) begin
         rd_mux[15:0] = {eeprom_protect_reg_q, pflash_protect_reg_q};
      end else if (hit(paddr, OFF_OPTION)) begin
         rd_mux[7:0] = option_reg_q;
      end else if (hit(paddr, OFF_COMMAND)) begin
         rd_mux[2:0] = cmd_q;
      end else if (hit(paddr, OFF_SEC_INFO)) begin
         rd_mux[2:0] = {debug_unsec_q, key_lock_q, secured};
      end else begin
         for (int i = 0; i < NUM_KEYS; i++) begin
            if (hit(paddr, OFF_KEY0 + 8'(4 * i))) begin
               rd_mux[15:0] = key_in_q[i];
            end
         end
      end
   end

   function automatic logic mapped(input logic [7:0] a);
      logic m;
      m = (a[1:0] == 2'h0) & ((a <= OFF_COMMAND) | (a == OFF_SEC_INFO)
          | ((a >= OFF_KEY0) & (a < OFF_SEC_INFO)));
      return m;
   endfunction

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_ph & ~pready;
         pslverr <= setup_ph & ~pready & ~mapped(paddr);
         if (setup_ph) begin
            prdata <= rd_mux;
         end
      end
   end

   // Software-owned enables and presented keys
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_done_irq_en_q <= 1'b0;
         single_fault_irq_en_q <= 1'b0;
         for (int i = 0; i < NUM_KEYS; i++) begin
            key_in_q[i] <= 16'h0000;
         end
      end else if (acc_wr) begin
         if (hit(paddr, OFF_SETUP)) begin
            cmd_done_irq_en_q <= pwdata[BIT_IRQ_EN];
         end
         if (hit(paddr, OFF_FAULT_SETUP)) begin
            single_fault_irq_en_q <= pwdata[BIT_IRQ_EN];
         end
         for (int i = 0; i < NUM_KEYS; i++) begin
            if (hit(paddr, OFF_KEY0 + 8'(4 * i))) begin
               key_in_q[i] <= pwdata[15:0];
            end
         end
      end
   end

   // Asynchronous reset drops any command in flight
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= ST_RD_REQ;
         idx_q <= 3'h0;
         cmd_q <= 3'h0;
      end else begin
         case (state_q)
            ST_RD_REQ: begin
               state_q <= ST_RD_WAIT;
            end
            ST_RD_WAIT: begin
               if (nvm_valid) begin
                  idx_q <= idx_q + 3'h1;
                  state_q <= (idx_q == CFG_LAST) ? ST_FIN : ST_RD_REQ;
               end
            end
            ST_FIN: begin
               state_q <= ST_IDLE;
            end
            ST_IDLE: begin
               if (launch & cmd_ok) begin
                  cmd_q <= pwdata[2:0];
                  state_q <= (pwdata[2:0] == CMD_VERIFY_KEY) ? ST_KEY : ST_ENG;
               end
            end
            ST_KEY: begin
               state_q <= ST_IDLE;
            end
            ST_ENG: begin
               if (eng_done) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_RD_REQ;
            end
         endcase
      end
   end

   // Configuration read port
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         nvm_rd <= 1'b0;
         nvm_addr <= CFG_BASE;
      end else begin
         nvm_rd <= (state_q == ST_RD_REQ);
         nvm_addr <= CFG_BASE + {20'h0_0000, idx_q, 1'b0};
      end
   end

   // Load configuration; security never reloaded afterwards
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         err_seen_q <= 1'b0;
         security_reg_q <= SEC_DEFAULT;
         pflash_protect_reg_q <= PROT_FULL;
         eeprom_protect_reg_q <= PROT_FULL;
         option_reg_q <= OPT_DEFAULT;
         for (int i = 0; i < NUM_KEYS; i++) begin
            key_stored_q[i] <= KEY_ONES;
         end
      end else if ((state_q == ST_RD_WAIT) && nvm_valid) begin
         err_seen_q <= err_seen_q | nvm_err | nvm_dbl_fault;
         for (int i = 0; i < NUM_KEYS; i++) begin
            if (idx_q == 3'(i)) begin
               key_stored_q[i] <= nvm_rdata;
            end
         end
         if (idx_q == CFG_PROT_IDX) begin
            {pflash_protect_reg_q, eeprom_protect_reg_q} <= nvm_rdata;
         end
         if (idx_q == CFG_SEC_IDX) begin
            {option_reg_q, security_reg_q} <= nvm_rdata;
         end
      end else if ((state_q == ST_FIN) && err_seen_q) begin
         // Faulty load falls back to locked-down values
         security_reg_q <= SEC_DEFAULT;
         pflash_protect_reg_q <= PROT_FULL;
         eeprom_protect_reg_q <= PROT_FULL;
         option_reg_q <= OPT_DEFAULT;
      end else if (key_phase && keys_match) begin
         // Only the live state field moves, never stored data
         security_reg_q.security_state_field <= SEC_UNSEC;
      end
   end

   // Lock out verify-key after a bad key
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         key_lock_q <= 1'b0;
      end else if (key_phase && !keys_match) begin
         key_lock_q <= 1'b1;
      end
   end

   // Erase-verify clean in special mode unsecures
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         debug_unsec_q <= 1'b0;
      end else if ((state_q == ST_ENG) && eng_done && (cmd_q == CMD_ERASE_VERIFY)
                   && special_mode && eng_erased) begin
         debug_unsec_q <= 1'b1;
      end
   end

   // Done flag low until init ends, cleared by launch, set by finish
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_done_flag_q <= 1'b0;
      end else if ((state_q == ST_FIN) || key_phase || ((state_q == ST_ENG) && eng_done)) begin
         cmd_done_flag_q <= 1'b1;
      end else if (launch && cmd_ok) begin
         cmd_done_flag_q <= 1'b0;
      end
   end

   // Sticky flags: a new event beats a same-cycle clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         accerr_q <= 1'b0;
         single_fault_flag_q <= 1'b0;
         verify_fault_bits_q <= 2'h0;
      end else begin
         if (launch && !cmd_ok) begin
            accerr_q <= 1'b1;
         end else if (acc_wr && hit(paddr, OFF_STATE) && pwdata[BIT_ACCERR]) begin
            accerr_q <= 1'b0;
         end
         if (rd_single_fault && (state_q != ST_KEY)) begin
            single_fault_flag_q <= 1'b1;
         end else if (acc_wr && hit(paddr, OFF_FAULT_STATE) && pwdata[BIT_SINGLE]) begin
            single_fault_flag_q <= 1'b0;
         end
         // Double fault in reset load marks both bits
         if ((state_q == ST_RD_WAIT) && nvm_valid && nvm_dbl_fault) begin
            verify_fault_bits_q <= 2'h3;
         end else if (launch && cmd_ok) begin
            verify_fault_bits_q <= 2'h0;
         end
      end
   end

   // Registered system outputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cpu_hold <= 1'b1;
         read_block <= 1'b0;
         eng_start <= 1'b0;
         eng_cmd <= 3'h0;
         stop_ack <= 1'b0;
         cmd_irq <= 1'b0;
         fault_irq <= 1'b0;
         secured <= 1'b1;
         debug_full_en <= 1'b0;
         security_out <= SEC_DEFAULT;
      end else begin
         // Hold processor through configuration reads only
         cpu_hold <= (state_q == ST_RD_REQ) || (state_q == ST_RD_WAIT);
         // Array reads refused during key check
         read_block <= launch && cmd_ok && (pwdata[2:0] == CMD_VERIFY_KEY);
         eng_start <= launch && cmd_ok && (pwdata[2:0] != CMD_VERIFY_KEY);
         eng_cmd <= (launch && cmd_ok) ? pwdata[2:0] : eng_cmd;
         // Stop granted only when nothing runs
         stop_ack <= stop_req && cmd_done_flag_q && (state_q == ST_IDLE) && !launch;
         // Level request, independent of wait mode
         cmd_irq <= cmd_done_flag_q && cmd_done_irq_en_q;
         fault_irq <= single_fault_flag_q && single_fault_irq_en_q;
         secured <= (security_reg_q.security_state_field != SEC_UNSEC) && !debug_unsec_q;
         debug_full_en <= debug_unsec_q || (security_reg_q.security_state_field == SEC_UNSEC);
         security_out <= security_reg_q;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_cmd_irq_level: assert property (cmd_done_flag_q && cmd_done_irq_en_q |=> cmd_irq)
      else $error("command irq missing");
   a_fault_irq_level: assert property (
      $past(single_fault_flag_q && single_fault_irq_en_q) == fault_irq)
      else $error("fault irq wrong");
   a_irq_drop: assert property (!cmd_done_irq_en_q |=> !cmd_irq)
      else $error("command irq not removed");
   a_stop_busy: assert property (!cmd_done_flag_q |=> !stop_ack)
      else $error("stop granted while busy");
   a_done_in_init: assert property (cpu_hold |-> !cmd_done_flag_q)
      else $error("done flag set during init");
   a_key_unsec: assert property (key_phase && keys_match |=>
      security_reg_q.security_state_field == SEC_UNSEC)
      else $error("keys matched but still secure");
   a_key_lock: assert property (key_phase && !keys_match |=> key_lock_q)
      else $error("verify-key not locked");
   a_lock_refuse: assert property (
      key_lock_q && launch && (pwdata[2:0] == CMD_VERIFY_KEY) |=> !read_block && key_lock_q)
      else $error("locked verify-key still ran");
   a_blank_key: assert property (key_phase && (key_in_q[0] == KEY_ONES) |=>
      key_lock_q)
      else $error("blank key accepted");
   a_prot_keep: assert property (key_phase |=> $stable(pflash_protect_reg_q)
      && $stable(option_reg_q))
      else $error("protection changed by key");
   a_read_block: assert property (state_q == ST_KEY |-> read_block)
      else $error("reads not blocked during key check");
   a_dbl_fault: assert property ((state_q == ST_RD_WAIT) && nvm_valid && nvm_dbl_fault
      |=> verify_fault_bits_q == 2'h3 ##1 1'b1)
      else $error("verify fault bits not set");

endmodule // flash_security_irq_init_ctrl

// *** sim/flash_far_side_model.sv ***
`timescale 1ns/1ns
module flash_far_side_model (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Bench controls
   input wire logic [63:0] keys,
   input wire logic [15:0] prot_word,
   input wire logic [15:0] optsec_word,
   input wire logic inj_err,
   input wire logic inj_dbl,
   input wire logic slow,
   input wire logic erased_in,
   // Configuration read port
   input wire logic nvm_rd,
   input wire logic [23:0] nvm_addr,
   output logic [15:0] nvm_rdata,
   output logic nvm_valid,
   output logic nvm_err,
   output logic nvm_dbl_fault,
   // Array engine
   input wire logic eng_start,
   output logic eng_done = 1'b0,
   output logic eng_erased = 1'b0
);
   logic rd_pend;
   logic [2:0] rd_idx;
   logic [4:0] rd_cnt;
   logic eng_pend = 1'b0;
   logic [4:0] eng_cnt = 5'h00;

   function automatic logic [15:0] word_at(input logic [2:0] i);
      if (i < 3'h4) return keys[16*i +: 16];
      if (i == 3'h6) return prot_word;
      if (i == 3'h7) return optsec_word;
      return 16'h0000;
   endfunction

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_pend <= 1'b0;
         rd_idx <= 3'h0;
         rd_cnt <= 5'h00;
         nvm_valid <= 1'b0;
         nvm_err <= 1'b0;
         nvm_dbl_fault <= 1'b0;
         nvm_rdata <= 16'h0000;
      end else begin
         nvm_valid <= 1'b0;
         nvm_err <= 1'b0;
         nvm_dbl_fault <= 1'b0;
         if (nvm_rd) begin
            rd_pend <= 1'b1;
            rd_idx <= nvm_addr[3:1];
            rd_cnt <= slow ? 5'h06 : 5'h00;
            nvm_rdata <= ~nvm_rdata;
         end else if (rd_pend && rd_cnt == 5'h00) begin
            rd_pend <= 1'b0;
            nvm_valid <= 1'b1;
            nvm_rdata <= word_at(rd_idx);
            nvm_err <= inj_err;
            nvm_dbl_fault <= inj_dbl;
         end else begin
            if (rd_pend) rd_cnt <= rd_cnt - 5'h01;
            // Stale data must not look valid
            nvm_rdata <= ~nvm_rdata;
         end
      end
   end

   // Engine ignores device reset, so a late completion can arrive
   always_ff @(posedge clk) begin
      eng_done <= 1'b0;
      if (eng_start) begin
         eng_pend <= 1'b1;
         eng_cnt <= slow ? 5'h14 : 5'h02;
      end else if (eng_pend && eng_cnt == 5'h00) begin
         eng_pend <= 1'b0;
         eng_done <= 1'b1;
         eng_erased <= erased_in;
      end else begin
         if (eng_pend) eng_cnt <= eng_cnt - 5'h01;
         eng_erased <= ~eng_erased;
      end
   end
endmodule // flash_far_side_model

// *** sim/flash_security_irq_init_ctrl_tb.sv ***
`timescale 1ns/1ns
module flash_security_irq_init_ctrl_tb;
   import flash_ctrl_pkg::*;
   localparam logic [63:0] KEY = 64'hdef0_9abc_5678_1234;
   logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, rerr, nvm_rd, nvm_valid, nvm_err, nvm_dbl_fault;
   logic [23:0] nvm_addr;
   logic [15:0] nvm_rdata, optsec_word = 16'h7e80;
   logic eng_start, eng_done, eng_erased, stop_ack, cpu_hold, read_block;
   logic cmd_irq, fault_irq, secured, debug_full_en;
   logic [2:0] eng_cmd, last_cmd = 3'h0;
   logic rd_single_fault = 1'b0, special_mode = 1'b0, stop_req = 1'b0;
   logic inj_err = 1'b0, inj_dbl = 1'b0, erased_in = 1'b0;
   logic [63:0] keys = KEY;
   security_t security_out;
   int n_fail = 0, check_count = 0, cyc = 0, blk_n = 0, blk0;

   always #50 clk = ~clk;

   flash_security_irq_init_ctrl i_flash_security_irq_init_ctrl (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_rd(nvm_rd),
      .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata), .nvm_valid(nvm_valid), .nvm_err(nvm_err),
      .nvm_dbl_fault(nvm_dbl_fault), .eng_start(eng_start), .eng_cmd(eng_cmd),
      .eng_done(eng_done), .eng_erased(eng_erased), .rd_single_fault(rd_single_fault),
      .special_mode(special_mode), .stop_req(stop_req), .stop_ack(stop_ack),
      .cpu_hold(cpu_hold), .read_block(read_block), .cmd_irq(cmd_irq), .fault_irq(fault_irq),
      .secured(secured), .debug_full_en(debug_full_en), .security_out(security_out));

   flash_far_side_model i_flash_far_side_model (.clk(clk), .sys_rst(sys_rst), .keys(keys),
      .prot_word(16'h5a3c), .optsec_word(optsec_word), .inj_err(inj_err), .inj_dbl(inj_dbl),
      .slow(1'b1), .erased_in(erased_in), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
      .nvm_rdata(nvm_rdata), .nvm_valid(nvm_valid), .nvm_err(nvm_err),
      .nvm_dbl_fault(nvm_dbl_fault), .eng_start(eng_start), .eng_done(eng_done),
      .eng_erased(eng_erased));

   task automatic tally_and_finish();
      if (n_fail == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (read_block === 1'b1) blk_n++;
      if (eng_start === 1'b1) last_cmd <= eng_cmd;
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, seen);
         n_fail++;
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Request stands until pready is seen high at a rising edge
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_done();
      for (int i = 0; i < 60; i++) begin
         apb(1'b0, OFF_STATE, 32'h0);
         if (rdat[BIT_DONE] === 1'b1) break;
      end
   endtask

   task automatic do_reset(input logic [15:0] osw, input logic e, input logic dbl);
      @(posedge clk);
      optsec_word <= osw;
      inj_err <= e;
      inj_dbl <= dbl;
      sys_rst <= 1'b1;
      repeat (20) @(posedge clk);
      check("hold_in_reset", cpu_hold, 32'h1);
      check("secured_in_reset", secured, 32'h1);
      sys_rst <= 1'b0;
      apb(1'b0, OFF_STATE, 32'h0);
      check("done_during_init", rdat[BIT_DONE], 32'h0);
      wait_done();
      check("done_after_init", rdat[BIT_DONE], 32'h1);
      check("hold_after_init", cpu_hold, 32'h0);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, rdat, exp);
   endtask

   task automatic verify_key(input logic [63:0] k);
      for (int i = 0; i < NUM_KEYS; i++) apb(1'b1, OFF_KEY0 + 8'(4 * i), {16'h0, k[16*i +: 16]});
      apb(1'b1, OFF_COMMAND, {29'h0, CMD_VERIFY_KEY});
      wait_done();
   endtask

   task automatic run_cmd(input logic [2:0] c);
      apb(1'b1, OFF_COMMAND, {29'h0, c});
      wait_done();
      check("engine_cmd", last_cmd, {29'h0, c});
   endtask

   task automatic s_init();
      do_reset(16'h7e80, 1'b0, 1'b0);
      rd_chk("security", OFF_SECURITY, 32'h80);
      check("security_out", security_out, 32'h80);
      rd_chk("protect", OFF_PROTECT, 32'h3c5a);
      rd_chk("option", OFF_OPTION, 32'h7e);
      rd_chk("unmapped_data", 8'h3c, 32'h0);
      check("unmapped_err", rerr, 32'h1);
   endtask

   task automatic s_irq();
      apb(1'b1, OFF_SETUP, 32'h1);
      repeat (2) @(posedge clk);
      check("cmd_irq_on", cmd_irq, 32'h1);
      apb(1'b1, OFF_SETUP, 32'h0);
      repeat (2) @(posedge clk);
      check("cmd_irq_off", cmd_irq, 32'h0);
      rd_single_fault <= 1'b1;
      @(posedge clk);
      rd_single_fault <= 1'b0;
      rd_chk("single_flag", OFF_FAULT_STATE, 32'h1);
      check("fault_irq_masked", fault_irq, 32'h0);
      apb(1'b1, OFF_FAULT_SETUP, 32'h1);
      repeat (2) @(posedge clk);
      check("fault_irq_on", fault_irq, 32'h1);
      apb(1'b1, OFF_FAULT_STATE, 32'h1);
      repeat (2) @(posedge clk);
      check("fault_irq_clear", fault_irq, 32'h0);
      apb(1'b1, OFF_FAULT_SETUP, 32'h0);
   endtask

   task automatic s_backdoor();
      blk0 = blk_n;
      verify_key(KEY ^ 64'h1);
      check("wrong_key_block", blk_n, blk0 + 1);
      verify_key(KEY);
      rd_chk("locked_sec", OFF_SECURITY, 32'h80);
      check("locked_no_check", blk_n, blk0 + 1);
      rd_chk("locked_info", OFF_SEC_INFO, 32'h3);
      do_reset(16'h7e80, 1'b0, 1'b0);
      verify_key(KEY);
      rd_chk("unsec_state", OFF_SECURITY, {24'h0, BACKDOOR_ON, 4'h0, SEC_UNSEC});
      check("unsec_out", secured, 32'h0);
      rd_chk("prot_kept", OFF_PROTECT, 32'h3c5a);
      do_reset(16'h7e80, 1'b0, 1'b0);
      rd_chk("byte_kept", OFF_SECURITY, 32'h80);
      keys <= {64{1'b1}};
      do_reset(16'h7e80, 1'b0, 1'b0);
      verify_key({64{1'b1}});
      check("ones_key", secured, 32'h1);
      keys <= KEY;
   endtask

   task automatic s_fallback();
      do_reset(16'h7e80, 1'b1, 1'b0);
      rd_chk("dflt_sec", OFF_SECURITY, {24'h0, SEC_DEFAULT});
      rd_chk("dflt_prot", OFF_PROTECT, {16'h0, PROT_FULL, PROT_FULL});
      rd_chk("dflt_opt", OFF_OPTION, {24'h0, OPT_DEFAULT});
      blk0 = blk_n;
      verify_key(KEY);
      check("backdoor_off", rdat[BIT_ACCERR], 32'h1);
      check("backdoor_off_chk", blk_n, blk0);
      do_reset(16'h7e80, 1'b0, 1'b1);
      check("dbl_fault_bits", rdat[1:0], 32'h3);
   endtask

   task automatic s_debug();
      special_mode <= 1'b1;
      erased_in <= 1'b0;
      do_reset(16'h7e80, 1'b0, 1'b0);
      apb(1'b1, OFF_COMMAND, {29'h0, CMD_ERASE_VERIFY});
      stop_req <= 1'b1;
      repeat (4) @(posedge clk);
      check("stop_wait", stop_ack, 32'h0);
      wait_done();
      repeat (2) @(posedge clk);
      check("stop_allowed", stop_ack, 32'h1);
      stop_req <= 1'b0;
      check("not_erased", debug_full_en, 32'h0);
      run_cmd(CMD_ERASE_ALL);
      run_cmd(CMD_UNSECURE);
      erased_in <= 1'b1;
      do_reset(16'h7e80, 1'b0, 1'b0);
      run_cmd(CMD_ERASE_VERIFY);
      check("debug_on", debug_full_en, 32'h1);
      check("debug_unsec", secured, 32'h0);
      rd_chk("debug_info", OFF_SEC_INFO, 32'h4);
      apb(1'b1, OFF_COMMAND, {29'h0, CMD_ERASE_VERIFY});
      repeat (3) @(posedge clk);
      do_reset(16'h7e80, 1'b0, 1'b0);
      check("abort_debug", debug_full_en, 32'h0);
      check("abort_secured", secured, 32'h1);
      special_mode <= 1'b0;
   endtask

   initial begin
      s_init();
      s_irq();
      s_backdoor();
      s_fallback();
      s_debug();
      tally_and_finish();
   end
endmodule // flash_security_irq_init_ctrl_tb
